// [hdl/keypad_wake_unit.sv]
/*
  Keypad wake unit: two pin interrupt units (eight pins on port A, four
  on port C pins 3..0), their port pad control, and an Avalon-MM slave.
  Assumes pins synchronous-ish but resynchronised here; the power
  manager supplies the current power mode and stops mclk in stop levels.
*/
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "kbi_cfg.svh"

module keypad_wake_unit
  import keypad_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Port pins
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_c_in,
  output pad_ctl_t port_a_pad,
  output pad_ctl_t port_c_pad,
  // Power mode
  input wire power_mode_t power_mode,
  // Requests
  output logic irq_a,
  output logic irq_b,
  output logic wake_req
);

  // Bus handshake
  logic ack_q;
  logic take;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_lane;

  // Per-unit state
  key_sc_t [1:0] sc_q;
  logic [1:0][7:0] pe_q;
  logic [1:0][7:0] mask;
  logic [1:0][3:0] pol_mask;
  logic [1:0][7:0] pins;
  logic [1:0][7:0] pol_full;
  logic [1:0][7:0] sync1_q;
  logic [1:0][7:0] sync2_q;
  logic [1:0][7:0] prev_q;
  logic [1:0][7:0] act_s;
  logic [1:0][7:0] act_raw;
  logic [1:0] sel_sc;
  logic [1:0] sel_pe;
  logic [1:0] irq;

  // Port control
  port_ctl_t pa_q;
  port_ctl_t pc_q;
  logic [7:0] pa_eff_dir;
  logic [7:0] pc_eff_dir;
  logic [7:0] pa_irq_pin;
  logic [7:0] pc_irq_pin;
  logic [7:0] pa_high;
  logic [7:0] pa_read;
  logic [7:0] pc_read;

  // One wait state: the slave answers in the cycle after the request
  assign take = ack_q & (read | write);
  assign waitrequest = (read | write) & ~ack_q;
  assign wr_lane = take & write & byteenable[0];
  assign readdata = rdata_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= `RDATA_RESET;
    end else if (read & ~ack_q) begin
      rdata_q <= rdata_d;
    end
  end

  // Unit wiring
  assign mask[0] = `UNIT_A_MASK;
  assign mask[1] = `UNIT_B_MASK;
  assign pol_mask[0] = `UNIT_A_POL_MASK;
  assign pol_mask[1] = `UNIT_B_POL_MASK;
  assign pins[0] = port_a_in;
  assign pins[1] = port_c_in & `UNIT_B_MASK;
  assign sel_sc[0] = (address == `OFS_A_SC);
  assign sel_sc[1] = (address == `OFS_B_SC);
  assign sel_pe[0] = (address == `OFS_A_PE);
  assign sel_pe[1] = (address == `OFS_B_PE);

  genvar u;
  generate
    for (u = 0; u < `KEY_UNITS; u++) begin : g_unit
      logic any_now;
      logic edge_evt;
      logic hold;
      logic ack_clr;
      logic flag_d;

      // Pins 3..0 carry a zero polarity bit: always active low
      assign pol_full[u] = {sc_q[u].edge_polarity_select & pol_mask[u],
                            `NIBBLE_ZERO};

      // Asserted level: pin equals its polarity bit
      assign act_raw[u] = ~(pins[u] ^ pol_full[u]) & pe_q[u]
                          & mask[u];
      assign act_s[u] = ~(sync2_q[u] ^ pol_full[u]) & pe_q[u]
                        & mask[u];

      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_q[u] <= `PORT_RESET;
          sync2_q[u] <= `PORT_RESET;
        end else begin
          sync1_q[u] <= pins[u];
          sync2_q[u] <= sync1_q[u];
        end
      end

      // Disabled pins count as deasserted in the previous sample
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          prev_q[u] <= `PORT_RESET;
        end else begin
          prev_q[u] <= act_s[u];
        end
      end

      assign any_now = |act_s[u];
      // Deasserted then asserted across two consecutive mclk samples
      assign edge_evt = sc_q[u].level_detect_mode ?
                        (any_now & ~(|prev_q[u])) :
                        |(act_s[u] & ~prev_q[u]);
      assign hold = sc_q[u].level_detect_mode & any_now;
      assign ack_clr = wr_lane & sel_sc[u] & writedata[`SC_ACK_BIT];
      // Set wins over acknowledge
      assign flag_d = edge_evt | hold
                      | (sc_q[u].key_event_flag & ~ack_clr);

      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          sc_q[u].key_event_flag <= 1'b0;
        end else begin
          sc_q[u].key_event_flag <= flag_d;
        end
      end

      // Acknowledge is not stored
      assign sc_q[u].key_event_acknowledge = 1'b0;

      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          sc_q[u].edge_polarity_select <= `NIBBLE_ZERO;
          sc_q[u].key_irq_enable <= 1'b0;
          sc_q[u].level_detect_mode <= 1'b0;
        end else if (wr_lane & sel_sc[u]) begin
          sc_q[u].edge_polarity_select <=
            writedata[`SC_POL_MSB:`SC_POL_LSB] & pol_mask[u];
          sc_q[u].key_irq_enable <= writedata[`SC_IE_BIT];
          sc_q[u].level_detect_mode <= writedata[`SC_MODE_BIT];
        end
      end

      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          pe_q[u] <= `PE_RESET;
        end else if (wr_lane & sel_pe[u]) begin
          pe_q[u] <= writedata[7:0] & mask[u];
        end
      end

      // Flag stays pollable with the enable off
      assign irq[u] = sc_q[u].key_irq_enable
                      & sc_q[u].key_event_flag;
    end
  endgenerate

  assign irq_a = irq[0];
  assign irq_b = irq[1];

  // Wake-up: clocks are off in the stop levels, so raw pins are used
  always_comb begin
    wake_req = 1'b0;
    unique case (power_mode)
      run_mode: begin
        wake_req = 1'b0;
      end
      wait_mode: begin
        wake_req = |irq;
      end
      standby_level: begin
        wake_req = |act_raw[0] | |act_raw[1];
      end
      partial_power_down_level,
      power_down_level: begin
        // Polarity is ignored here; only low levels wake
        wake_req = |(~port_a_in & pe_q[0])
                   | |(~pins[1] & pe_q[1] & mask[1]);
      end
      default: begin
        wake_req = 1'b0;
      end
    endcase
  end

  // Port registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pa_q <= {`PORT_RESET, `PORT_RESET, `PORT_RESET};
    end else if (wr_lane) begin
      if (address == `OFS_PA_VAL) begin
        pa_q.value <= writedata[7:0];
      end
      if (address == `OFS_PA_DIR) begin
        pa_q.direction <= writedata[7:0];
      end
      if (address == `OFS_PA_PULL) begin
        pa_q.pull <= writedata[7:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pc_q <= {`PORT_RESET, `PORT_RESET, `PORT_RESET};
    end else if (wr_lane) begin
      if (address == `OFS_PC_VAL) begin
        pc_q.value <= writedata[7:0];
      end
      if (address == `OFS_PC_DIR) begin
        pc_q.direction <= writedata[7:0];
      end
      if (address == `OFS_PC_PULL) begin
        pc_q.pull <= writedata[7:0];
      end
    end
  end

  // Interrupt pins override the direction register
  assign pa_irq_pin = pe_q[0];
  assign pc_irq_pin = pe_q[1] & `UNIT_B_MASK;
  assign pa_eff_dir = pa_q.direction & ~pa_irq_pin;
  assign pc_eff_dir = pc_q.direction & ~pc_irq_pin;
  assign pa_high = pa_irq_pin & pol_full[0] & `UPPER_PINS;

  assign pa_read = (pa_eff_dir & pa_q.value) | (~pa_eff_dir & port_a_in);
  assign pc_read = (pc_eff_dir & pc_q.value) | (~pc_eff_dir & port_c_in);

  // Pull acts on every input, interrupt pins included
  assign port_a_pad.out = pa_q.value;
  assign port_a_pad.oe_n = ~pa_eff_dir;
  assign port_a_pad.pull_up_en = pa_q.pull & ~pa_eff_dir
                                 & ~pa_high;
  assign port_a_pad.pull_down_en = pa_q.pull & ~pa_eff_dir
                                   & pa_high;
  assign port_c_pad.out = pc_q.value;
  assign port_c_pad.oe_n = ~pc_eff_dir;
  // Unit B has no polarity choice, so port C never pulls down
  assign port_c_pad.pull_up_en = pc_q.pull & ~pc_eff_dir;
  assign port_c_pad.pull_down_en = `BYTE_ZERO;

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rdata_d = `RDATA_RESET;
    unique case (address)
      `OFS_A_SC: rdata_d = {`UPPER_ZERO, sc_q[0]};
      `OFS_A_PE: rdata_d = {`UPPER_ZERO, pe_q[0]};
      `OFS_B_SC: rdata_d = {`UPPER_ZERO, sc_q[1]};
      `OFS_B_PE: rdata_d = {`UPPER_ZERO, pe_q[1]};
      `OFS_PA_VAL: rdata_d = {`UPPER_ZERO, pa_read};
      `OFS_PA_DIR: rdata_d = {`UPPER_ZERO, pa_q.direction};
      `OFS_PA_PULL: rdata_d = {`UPPER_ZERO, pa_q.pull};
      `OFS_PC_VAL: rdata_d = {`UPPER_ZERO, pc_read};
      `OFS_PC_DIR: rdata_d = {`UPPER_ZERO, pc_q.direction};
      `OFS_PC_PULL: rdata_d = {`UPPER_ZERO, pc_q.pull};
      default: rdata_d = `RDATA_RESET;
    endcase
  end

endmodule // keypad_wake_unit

`default_nettype wire

// [hdl/kbi_cfg.svh]
/*
  Constants for the keypad wake unit: register offsets, field positions,
  reset values and pin masks. Assumes inclusion by bare name.
*/
`ifndef KEYPAD_CFG_SVH
`define KEYPAD_CFG_SVH

// Unit count and pin width of the widest unit
`define KEY_UNITS 2
`define KEY_WIDTH 8

// Which unit pins exist
`define UNIT_A_MASK 8'hFF
`define UNIT_B_MASK 8'h0F
// Polarity bits that exist per unit (pins 7..4)
`define UNIT_A_POL_MASK 4'hF
`define UNIT_B_POL_MASK 4'h0
// Pins 7..4 of a unit, the only ones with selectable polarity
`define UPPER_PINS 8'hF0

// Byte offsets on the register bus
`define OFS_A_SC 6'h00
`define OFS_A_PE 6'h04
`define OFS_B_SC 6'h08
`define OFS_B_PE 6'h0C
`define OFS_PA_VAL 6'h10
`define OFS_PA_DIR 6'h14
`define OFS_PA_PULL 6'h18
`define OFS_PC_VAL 6'h1C
`define OFS_PC_DIR 6'h20
`define OFS_PC_PULL 6'h24

// Status/control field positions
`define SC_FLAG_BIT 3
`define SC_ACK_BIT 2
`define SC_IE_BIT 1
`define SC_MODE_BIT 0
`define SC_POL_LSB 4
`define SC_POL_MSB 7

// Reset values
`define SC_RESET 8'h00
`define PE_RESET 8'h00
`define PORT_RESET 8'h00
`define RDATA_RESET 32'h0000_0000
`define BYTE_ZERO 8'h00
`define UPPER_ZERO 24'h00_0000
`define NIBBLE_ZERO 4'h0

`endif

// [hdl/kbi_pkg.sv]
/*
  Types for the keypad wake unit: status/control layout, port control
  group, pad control group and power modes. Assumes kbi_cfg.svh.
*/
package keypad_pkg;

  typedef struct packed {
    logic [3:0] edge_polarity_select;
    logic key_event_flag;
    logic key_event_acknowledge;
    logic key_irq_enable;
    logic level_detect_mode;
  } key_sc_t;

  typedef struct packed {
    logic [7:0] value;
    logic [7:0] direction;
    logic [7:0] pull;
  } port_ctl_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pull_up_en;
    logic [7:0] pull_down_en;
  } pad_ctl_t;

  typedef enum logic [4:0] {
    run_mode = 5'h01,
    wait_mode = 5'h02,
    standby_level = 5'h04,
    partial_power_down_level = 5'h08,
    power_down_level = 5'h10
  } power_mode_t;

endpackage

// [bench/keypad_wake_unit_checker.sv]
/*
  Port checker for the keypad wake unit, bound to its top module.
  Assumes kbi_pkg compiled first and kbi_cfg.svh on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "kbi_cfg.svh"

module keypad_wake_unit_checker
  import keypad_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register bus
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Pins and requests
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_c_in,
  input wire pad_ctl_t port_a_pad,
  input wire pad_ctl_t port_c_pad,
  input wire power_mode_t power_mode,
  input wire logic irq_a,
  input wire logic irq_b,
  input wire logic wake_req
);
  logic acc;
  logic [7:0] sc_a_q, pe_a_q, pe_b_q, dir_a_q, pull_a_q, pd_a, pol_a;
  logic [7:0] dir_c_q, pull_c_q;
  assign acc = write && !waitrequest && byteenable[0];
  assign pol_a = {sc_a_q[7:4], 4'h0};
  assign pd_a = pull_a_q & pe_a_q & pol_a;

  // Shadow of bus-written controls, taken on the accepting edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sc_a_q <= 8'h00;
      pe_a_q <= 8'h00;
      pe_b_q <= 8'h00;
      dir_a_q <= 8'h00;
      pull_a_q <= 8'h00;
      dir_c_q <= 8'h00;
      pull_c_q <= 8'h00;
    end else if (acc) begin
      case (address)
        `OFS_A_SC: sc_a_q <= writedata[7:0];
        `OFS_A_PE: pe_a_q <= writedata[7:0];
        `OFS_B_PE: pe_b_q <= {4'h0, writedata[3:0]};
        `OFS_PA_DIR: dir_a_q <= writedata[7:0];
        `OFS_PA_PULL: pull_a_q <= writedata[7:0];
        `OFS_PC_DIR: dir_c_q <= writedata[7:0];
        `OFS_PC_PULL: pull_c_q <= writedata[7:0];
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_fall0;
    sc_a_q[1] && !sc_a_q[0] && pe_a_q[0] && $past(port_a_in[0])
      && !port_a_in[0];
  endsequence
  sequence s_held5;
    (sc_a_q[0] && sc_a_q[1] && sc_a_q[5] && pe_a_q[5] && port_a_in[5])[*6];
  endsequence

  a_ack_reads_zero: assert property (
    read && !waitrequest && (address == `OFS_A_SC || address == `OFS_B_SC)
      |-> !readdata[2] && readdata[31:8] == 24'h0)
    else $error("ack bit or upper bits read nonzero");
  a_pin_forced_in: assert property (
    port_a_pad.oe_n == ~(dir_a_q & ~pe_a_q))
    else $error("interrupt pin not forced to input");
  a_pull_swap: assert property (
    port_a_pad.pull_down_en == pd_a && port_a_pad.pull_up_en ==
      (pull_a_q & (~dir_a_q | pe_a_q) & ~pd_a))
    else $error("pull device selection wrong");
  a_pin_c_in: assert property (
    port_c_pad.oe_n == ~(dir_c_q & ~pe_b_q) && port_c_pad.pull_down_en == 0
      && port_c_pad.pull_up_en == (pull_c_q & (~dir_c_q | pe_b_q)))
    else $error("port C pad control wrong");
  a_irq_needs_ie: assert property (!sc_a_q[1] |-> !irq_a)
    else $error("request raised with enable off");
  a_fall_to_irq: assert property (s_fall0 |-> ##[1:4] irq_a)
    else $error("falling edge did not raise request");
  a_level_hold: assert property (s_held5 |-> irq_a)
    else $error("level mode flag not held");
  a_wake_deep: assert property (
    power_mode inside {partial_power_down_level, power_down_level} |->
      wake_req == |{pe_a_q & ~port_a_in, pe_b_q[3:0] & ~port_c_in[3:0]})
    else $error("deep stop wake mismatch");
  a_wake_standby: assert property (
    power_mode == standby_level |-> wake_req ==
      |{pe_a_q & ~(port_a_in ^ pol_a), pe_b_q[3:0] & ~port_c_in[3:0]})
    else $error("standby wake mismatch");
  a_wake_wait: assert property (
    power_mode == wait_mode |-> wake_req == (irq_a || irq_b))
    else $error("wait wake mismatch");
endmodule // keypad_wake_unit_checker

bind keypad_wake_unit keypad_wake_unit_checker keypad_wake_unit_checker_i (
  .mclk(mclk), .reset_n(reset_n), .address(address), .read(read),
  .write(write), .byteenable(byteenable), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .port_a_in(port_a_in),
  .port_c_in(port_c_in), .port_a_pad(port_a_pad), .port_c_pad(port_c_pad),
  .power_mode(power_mode), .irq_a(irq_a), .irq_b(irq_b),
  .wake_req(wake_req));
`default_nettype wire

// [bench/key_source_model.sv]
/*
  Key switches on one port: pressed keys pull to their asserted level.
  Assumes the unit's pad control; driven pins follow the port output.
*/
`timescale 1ns/100ps
`default_nettype none

module key_source_model
  import keypad_pkg::*;
(
  // From the unit
  input wire pad_ctl_t pad,
  // Keys held and their asserted level
  input wire logic [7:0] press,
  input wire logic [7:0] act_high,
  // Pin levels
  output logic [7:0] level
);
  // Released keys rest deasserted, so edges can be seen
  assign level = (~pad.oe_n & pad.out) | (pad.oe_n & (press ~^ act_high));
endmodule // key_source_model
`default_nettype wire

// [bench/keypad_wake_unit_tb.sv]
/*
  Self-checking bench for the keypad wake unit: bus master, key models,
  expectation queue checked on each read. Assumes checker bound.
*/
`timescale 1ns/100ps
`default_nettype none
`include "kbi_cfg.svh"

module keypad_wake_unit_tb
  import keypad_pkg::*;
;
  logic mclk, reset_n, read, write, irq_a, irq_b, wake_req, waitrequest;
  logic [5:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, rnd;
  logic [7:0] port_a_in, port_c_in, press_a, press_c, hi_a;
  logic [33:0] exp_q[$];
  logic [33:0] got, want;
  pad_ctl_t port_a_pad, port_c_pad;
  power_mode_t power_mode;
  int error_cnt, check_count;

  keypad_wake_unit keypad_wake_unit_i (.mclk(mclk), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .port_a_in(port_a_in), .port_c_in(port_c_in), .port_a_pad(port_a_pad),
    .port_c_pad(port_c_pad), .power_mode(power_mode), .irq_a(irq_a),
    .irq_b(irq_b), .wake_req(wake_req));
  key_source_model key_a_i (.pad(port_a_pad), .press(press_a),
    .act_high(hi_a), .level(port_a_in));
  key_source_model key_c_i (.pad(port_c_pad), .press(press_c),
    .act_high(8'h00), .level(port_c_in));

  always #50 mclk = ~mclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] a,
      input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    read <= !wr;
    write <= wr;
    // Waitrequest seen at the edge, before the slave's flops update
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      $display("[ERR] %0t bus timeout got %h exp %h", $time, waitrequest,
        1'b0);
      wrap_up();
    end else begin
      @(posedge mclk);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  // Expected data plus {irq_a, irq_b} noted before the read
  task automatic rd(input logic [5:0] a, input logic [7:0] d,
      input logic [1:0] irq);
    exp_q.push_back({irq, 24'h0, d});
    bus(1'b0, a, 8'h00, 4'hF);
  endtask

  // Read data valid in the low-waitrequest cycle; sampled mid-cycle
  always @(negedge mclk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      got = {irq_a, irq_b, readdata};
      want = exp_q.pop_front();
      check_count++;
      if (got !== want) begin
        error_cnt++;
        $display("[ERR] %0t got %h exp %h", $time, got, want);
      end
    end
  end

  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    {read, write, address, writedata, byteenable} = '0;
    {press_a, press_c, hi_a} = '0;
    power_mode = run_mode;
    error_cnt = 0;
    check_count = 0;
    rnd = 32'hEA99;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    // Idle pins read high; unmapped words read zero
    for (int i = 0; i < 16; i++) begin
      rd(6'(i * 4), (i == 4 || i == 7) ? 8'hFF : 8'h00, 2'b00);
    end
    rnd = lfsr(rnd);
    wr(`OFS_PA_DIR, 8'hFF);
    // Low nibble high so enabling those pins makes no edge
    wr(`OFS_PA_VAL, {rnd[7:4], 4'hF});
    wr(`OFS_A_PE, 8'h0F);
    rd(`OFS_PA_VAL, {rnd[7:4], 4'hF}, 2'b00);
    wr(`OFS_PA_DIR, 8'h00);
    wr(`OFS_A_PE, 8'hFF);
    wr(`OFS_A_SC, 8'h06);
    rd(`OFS_A_SC, 8'h02, 2'b00);
    press_a <= 8'h04;
    tick(6);
    rd(`OFS_A_SC, 8'h0A, 2'b10);
    wr(`OFS_A_SC, 8'h06);
    rd(`OFS_A_SC, 8'h02, 2'b00);
    press_a <= 8'h00;
    wr(`OFS_A_SC, 8'h00);
    press_a <= 8'h02;
    tick(6);
    rd(`OFS_A_SC, 8'h08, 2'b00);
    press_a <= 8'h00;
    wr(`OFS_A_PE, 8'h00);
    hi_a <= 8'h20;
    wr(`OFS_PA_PULL, 8'hFF);
    wr(`OFS_A_PE, 8'h20);
    wr(`OFS_A_SC, 8'h26);
    rd(`OFS_A_SC, 8'h22, 2'b00);
    press_a <= 8'h20;
    tick(6);
    rd(`OFS_A_SC, 8'h2A, 2'b10);
    press_a <= 8'h00;
    tick(6);
    wr(`OFS_A_SC, 8'h27);
    rd(`OFS_A_SC, 8'h23, 2'b00);
    press_a <= 8'h20;
    tick(6);
    wr(`OFS_A_SC, 8'h27);
    rd(`OFS_A_SC, 8'h2B, 2'b10);
    press_a <= 8'h00;
    tick(6);
    wr(`OFS_A_SC, 8'h26);
    rd(`OFS_A_SC, 8'h22, 2'b00);
    wr(`OFS_B_PE, 8'hFF);
    rd(`OFS_B_PE, 8'h0F, 2'b00);
    wr(`OFS_B_SC, 8'hF6);
    rd(`OFS_B_SC, 8'h02, 2'b00);
    press_c <= 8'h80;
    tick(6);
    rd(`OFS_B_SC, 8'h02, 2'b00);
    press_c <= 8'h08;
    tick(6);
    rd(`OFS_B_SC, 8'h0A, 2'b01);
    press_c <= 8'h00;
    wr(`OFS_B_SC, 8'h04);
    bus(1'b1, `OFS_A_PE, 8'hFF, 4'hE);
    rd(`OFS_A_PE, 8'h20, 2'b00);
    wr(`OFS_A_PE, 8'h21);
    // Every power mode, random keys; wake is judged by the checker
    for (int i = 0; i < 20; i++) begin
      rnd = lfsr(rnd);
      power_mode <= power_mode_t'(5'h01 << (i % 5));
      press_a <= rnd[7:0];
      press_c <= {4'h0, rnd[11:8]};
      tick(3);
    end
    power_mode <= run_mode;
    wrap_up();
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
endmodule // keypad_wake_unit_tb
`default_nettype wire
